// File: mrx_defines.svh
// constants for the move and return executer
// Functional notes
// RL1 - store_acc_to_file copies work_register into file register 0..63, one cycle, flags kept
// RL2 - file_move_with_test reads file register, writes work_register (d=0) or itself (d=1)
// RL3 - file_move_with_test sets zero flag when moved value is zero, else clears
// RL4 - return_with_literal loads immediate, pops stack to pc, sets enable, two cycles
// RL5 - return_from_irq pops stack to pc, sets global_irq_enable, two cycles, flags kept
// RL6 - subroutine_return pops stack to pc in two cycles, enable and flags kept
// RL7 - every return takes pc from entry at current level, then lowers level
// RL8 - no-operation changes nothing but advances pc by one in one cycle
`ifndef MRX_DEFINES_SVH
`define MRX_DEFINES_SVH
// register byte offsets
`define MRX_CMD_OFF 8'h00
`define MRX_WORK_OFF 8'h04
`define MRX_FLAGS_OFF 8'h08
`define MRX_PC_OFF 8'h0c
`define MRX_LEVEL_OFF 8'h10
`define MRX_STACK_OFF 8'h14
`define MRX_FADDR_OFF 8'h18
`define MRX_FDATA_OFF 8'h1c
`define MRX_OFF_W 8
// flags register bit positions
`define MRX_ZERO_BIT 0
`define MRX_GIE_BIT 1
`define MRX_BUSY_BIT 2
// widths and reset values
`define MRX_PC_W 10
`define MRX_FILE_AW 6
`define MRX_FILE_DEPTH 64
`define MRX_LEVEL_W 4
`define MRX_STACK_DEPTH 8
`define MRX_PC_RESET 10'h000
`define MRX_WORK_RESET 8'h00
`define MRX_PC_STEP 10'h001
`define MRX_LEVEL_STEP 4'h1
`define MRX_HTRANS_ACTIVE_BIT 1
`endif

// File: mrx_pkg.sv
// types shared by the move and return executer
package mrx_pkg;
    typedef enum logic [2:0] {
        OP_NOP = 3'b000,
        OP_STORE_ACC_TO_FILE = 3'b001,
        OP_FILE_MOVE_WITH_TEST = 3'b010,
        OP_RETURN_WITH_LITERAL = 3'b011,
        OP_RETURN_FROM_IRQ = 3'b100,
        OP_SUBROUTINE_RETURN = 3'b101
    } mrx_op_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RETURN = 1'b1
    } mrx_state_type;

    // layout of a word written to the command register
    typedef struct packed {
        logic [7:0] spare_hi;
        logic [7:0] literal;
        logic [5:0] spare_mid;
        logic [5:0] file_addr;
        logic to_file;
        logic [2:0] op;
    } mrx_cmd_type;
endpackage

// File: mrx_stack.sv
// hardware return stack with a level pointer
`timescale 1ns/100ps
`default_nettype none
module mrx_stack #(
    parameter int DEPTH = 8,
    parameter int DATA_W = 10,
    parameter int LEVEL_W = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic push,
    input wire logic pop,
    input wire logic [DATA_W-1:0] push_data,
    input wire logic load_level,
    input wire logic [LEVEL_W-1:0] level_data,
    output logic [DATA_W-1:0] top_data,
    output logic [LEVEL_W-1:0] level
);
    logic [DATA_W-1:0] mem [0:DEPTH];
    localparam logic [LEVEL_W-1:0] MAX_LEVEL = LEVEL_W'(DEPTH);

    // entry at the current level is the return address
    assign top_data = mem[level]; // RL7

    // level pointer: pop lowers, push raises, both saturate
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            level <= '0;
        end else if (ce) begin
            if (pop) begin
                if (level != '0) begin
                    level <= level - LEVEL_W'(1); // RL7
                end
            end else if (push) begin
                if (level != MAX_LEVEL) begin
                    level <= level + LEVEL_W'(1);
                end
            end else if (load_level) begin
                level <= (level_data > MAX_LEVEL) ? MAX_LEVEL : level_data;
            end
        end
    end

    // push stores at the level above the current one
    always_ff @(posedge clock) begin
        if (ce && push && !pop && level != MAX_LEVEL) begin
            mem[level + LEVEL_W'(1)] <= push_data;
        end
    end
endmodule
`default_nettype wire

// File: mrx_exec.sv
// executer for file moves and returns, with an ahb-lite register slave
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mrx_defines.svh"
module mrx_exec
    import mrx_pkg::*;
#(
    parameter int STACK_DEPTH = `MRX_STACK_DEPTH
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic GLOBAL_IRQ_ENABLE,
    output logic BUSY
);
    logic wr_pend;
    logic rd_pend;
    logic [`MRX_OFF_W-1:0] wr_addr;
    logic [`MRX_OFF_W-1:0] rd_addr;
    logic [31:0] rd_value;
    logic [7:0] work_register;
    logic zero_flag;
    logic [`MRX_PC_W-1:0] pc;
    logic [`MRX_FILE_AW-1:0] file_addr;
    logic [7:0] file_mem [0:`MRX_FILE_DEPTH-1];
    mrx_state_type state;
    mrx_cmd_type cmd;
    mrx_cmd_type held;
    mrx_op_type op;
    logic start;
    logic finish_return;
    logic [7:0] moved;
    logic [`MRX_PC_W-1:0] stack_top;
    logic [`MRX_LEVEL_W-1:0] level;
    logic stack_push;
    logic level_load;

    // write data phase decode; a command starts only when idle
    assign cmd = mrx_cmd_type'(HWDATA);
    assign op = mrx_op_type'(cmd.op);
    assign start = wr_pend && wr_addr == `MRX_CMD_OFF && state == ST_IDLE;
    assign finish_return = state == ST_RETURN;
    assign moved = file_mem[cmd.file_addr];
    assign stack_push = wr_pend && wr_addr == `MRX_STACK_OFF && !finish_return;
    assign level_load = wr_pend && wr_addr == `MRX_LEVEL_OFF && !finish_return;

    // bus slave: writes zero-wait, reads one wait state so data is registered
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= '0;
            rd_addr <= '0;
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else if (CE) begin
            wr_pend <= 1'b0;
            HRESP <= 1'b0; // always okay
            if (rd_pend) begin
                HRDATA <= rd_value;
                HREADYOUT <= 1'b1;
                rd_pend <= 1'b0;
            end else if (HSEL && HREADYOUT && HTRANS[`MRX_HTRANS_ACTIVE_BIT]) begin
                if (HWRITE) begin
                    wr_pend <= 1'b1;
                    wr_addr <= HADDR[`MRX_OFF_W-1:0];
                end else begin
                    rd_pend <= 1'b1;
                    rd_addr <= HADDR[`MRX_OFF_W-1:0];
                    HREADYOUT <= 1'b0;
                end
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_value = 32'h0000_0000;
        case (rd_addr)
            `MRX_WORK_OFF: rd_value[7:0] = work_register;
            `MRX_FLAGS_OFF: begin
                rd_value[`MRX_ZERO_BIT] = zero_flag;
                rd_value[`MRX_GIE_BIT] = GLOBAL_IRQ_ENABLE;
                rd_value[`MRX_BUSY_BIT] = BUSY;
            end
            `MRX_PC_OFF: rd_value[`MRX_PC_W-1:0] = pc;
            `MRX_LEVEL_OFF: rd_value[`MRX_LEVEL_W-1:0] = level;
            `MRX_STACK_OFF: rd_value[`MRX_PC_W-1:0] = stack_top;
            `MRX_FADDR_OFF: rd_value[`MRX_FILE_AW-1:0] = file_addr;
            `MRX_FDATA_OFF: rd_value[7:0] = file_mem[file_addr];
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // sequencer: returns take a second cycle to pop the stack
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            state <= ST_IDLE;
            held <= '0;
            BUSY <= 1'b0;
        end else if (CE) begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        held <= cmd;
                        case (op)
                            OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_IRQ, OP_SUBROUTINE_RETURN: begin
                                state <= ST_RETURN; // RL4 RL5 RL6
                                BUSY <= 1'b1;
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end
                end
                ST_RETURN: begin
                    state <= ST_IDLE;
                    BUSY <= 1'b0;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // work register: software write, file move, literal on return
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            work_register <= `MRX_WORK_RESET;
        end else if (CE) begin
            if (finish_return && mrx_op_type'(held.op) == OP_RETURN_WITH_LITERAL) begin
                work_register <= held.literal; // RL4
            end else if (start && op == OP_FILE_MOVE_WITH_TEST && !cmd.to_file) begin
                work_register <= moved; // RL2
            end else if (wr_pend && wr_addr == `MRX_WORK_OFF) begin
                work_register <= HWDATA[7:0];
            end
        end
    end

    // zero flag: only the file move and a software write to the flags register touch it
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            zero_flag <= 1'b0;
        end else if (CE) begin
            if (start && op == OP_FILE_MOVE_WITH_TEST) begin
                zero_flag <= (moved == 8'h00); // RL3
            end else if (wr_pend && wr_addr == `MRX_FLAGS_OFF) begin
                zero_flag <= HWDATA[`MRX_ZERO_BIT];
            end
        end
    end

    // global interrupt enable: set by two of the returns
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            GLOBAL_IRQ_ENABLE <= 1'b0;
        end else if (CE) begin
            if (finish_return && mrx_op_type'(held.op) != OP_SUBROUTINE_RETURN) begin
                GLOBAL_IRQ_ENABLE <= 1'b1; // RL4 RL5
            end else if (wr_pend && wr_addr == `MRX_FLAGS_OFF) begin
                GLOBAL_IRQ_ENABLE <= HWDATA[`MRX_GIE_BIT];
            end
        end
    end

    // program counter: step on one-cycle ops, stack top on returns
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            pc <= `MRX_PC_RESET;
        end else if (CE) begin
            if (finish_return) begin
                pc <= stack_top; // RL6 RL7
            end else if (start && op != OP_RETURN_WITH_LITERAL && op != OP_RETURN_FROM_IRQ
                         && op != OP_SUBROUTINE_RETURN) begin
                pc <= pc + `MRX_PC_STEP; // RL8
            end else if (wr_pend && wr_addr == `MRX_PC_OFF) begin
                pc <= HWDATA[`MRX_PC_W-1:0];
            end
        end
    end

    // file address pointer for software access
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            file_addr <= '0;
        end else if (CE && wr_pend && wr_addr == `MRX_FADDR_OFF) begin
            file_addr <= HWDATA[`MRX_FILE_AW-1:0];
        end
    end

    // file registers: instruction writes, else software writes
    always_ff @(posedge CLOCK) begin
        if (CE) begin
            if (start && op == OP_STORE_ACC_TO_FILE) begin
                file_mem[cmd.file_addr] <= work_register; // RL1
            end else if (start && op == OP_FILE_MOVE_WITH_TEST && cmd.to_file) begin
                file_mem[cmd.file_addr] <= moved; // RL2
            end else if (wr_pend && wr_addr == `MRX_FDATA_OFF) begin
                file_mem[file_addr] <= HWDATA[7:0];
            end
        end
    end

    // return stack
    mrx_stack #(
        .DEPTH(STACK_DEPTH),
        .DATA_W(`MRX_PC_W),
        .LEVEL_W(`MRX_LEVEL_W)
    ) u_stack (
        .clock(CLOCK),
        .rst_b(RST_B),
        .ce(CE),
        .push(stack_push),
        .pop(finish_return), // RL7
        .push_data(HWDATA[`MRX_PC_W-1:0]),
        .load_level(level_load),
        .level_data(HWDATA[`MRX_LEVEL_W-1:0]),
        .top_data(stack_top),
        .level(level)
    );
endmodule
`default_nettype wire

// File: mrx_exec_props.sv
// port assertions for the move and return executer
`timescale 1ns/100ps
`default_nettype none
module mrx_exec_props (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic BUSY
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    logic cmd_ph;
    wire taken = CE && HSEL && HTRANS[1] && HREADYOUT;
    wire [2:0] op = HWDATA[2:0];
    wire go = cmd_ph && CE && !BUSY;
    // marks the data phase of a command write
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            cmd_ph <= 1'b0;
        end else if (CE) begin
            cmd_ph <= taken && HWRITE && HADDR[7:0] == 8'h00;
        end
    end
    AST_RET_BUSY: assert property (go && op inside {3'h3, 3'h4, 3'h5} |=> BUSY)
        else $error("return did not raise busy");
    AST_BUSY_ONE: assert property (BUSY && CE |=> !BUSY)
        else $error("busy held past the second cycle");
    AST_SHORT_OPS: assert property (go && !(op inside {3'h3, 3'h4, 3'h5}) |=> !BUSY)
        else $error("single cycle op raised busy");
    AST_RET_GIE: assert property (go && op inside {3'h3, 3'h4} |=> ##1 GLOBAL_IRQ_ENABLE)
        else $error("return did not set the enable");
    AST_RET_KEEP: assert property (go && op == 3'h5 |=> ##1 $stable(GLOBAL_IRQ_ENABLE))
        else $error("plain return changed the enable");
    AST_READ_WAIT: assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (taken && HWRITE |=> HREADYOUT)
        else $error("write was stalled");
    AST_OKAY: assert property (HRESP == 1'b0)
        else $error("response not okay");
endmodule
bind mrx_exec mrx_exec_props u_props (
    .CLOCK(CLOCK),
    .RST_B(RST_B),
    .CE(CE),
    .HSEL(HSEL),
    .HADDR(HADDR),
    .HTRANS(HTRANS),
    .HWRITE(HWRITE),
    .HWDATA(HWDATA),
    .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT),
    .HRESP(HRESP),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .BUSY(BUSY)
);
`default_nettype wire

// File: tb_mrx_exec.sv
// self-checking bench for the move and return executer
`timescale 1ns/100ps
`default_nettype none
`include "mrx_defines.svh"
module tb_mrx_exec
    import mrx_pkg::*;
;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic CE = 1'b1;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, GLOBAL_IRQ_ENABLE, BUSY;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    mrx_exec uut (.CLOCK(CLOCK), .RST_B(RST_B), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .BUSY(BUSY));
    // clock and hang guard
    always #10 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("MISMATCH timeout expected done seen running");
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one single ahb-lite transfer, waits on hready in both phases
    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= is_wr;
        HADDR <= {24'h0, a};
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask
    task automatic chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        xfer(1'b0, a, 32'h0, got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // compares a single output pin sampled at a clock edge
    task automatic chk_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    function automatic logic [31:0] cmd(logic [2:0] op, logic d, logic [5:0] fa, logic [7:0] lit);
        mrx_cmd_type c = '{8'h00, lit, 6'h00, fa, d, op};
        return c;
    endfunction
    // test sequence
    initial begin
        repeat (8) @(posedge CLOCK);
        RST_B <= 1'b1;
        chk("flags", `MRX_FLAGS_OFF, 32'h0);
        chk("unmapped", 8'h40, 32'h0);
        chk_bit("response", 1'b0, HRESP);
        $display("reset test done");
        wr(`MRX_WORK_OFF, 32'haa);
        wr(`MRX_FLAGS_OFF, 32'h1);
        wr(`MRX_CMD_OFF, cmd(OP_STORE_ACC_TO_FILE, 1'b0, 6'h3f, 8'h00));
        wr(`MRX_FADDR_OFF, 32'h3f);
        chk("file", `MRX_FDATA_OFF, 32'haa);
        chk("flags", `MRX_FLAGS_OFF, 32'h1);
        chk("pc", `MRX_PC_OFF, 32'h1);
        $display("store test done");
        wr(`MRX_FLAGS_OFF, 32'h0);
        wr(`MRX_FADDR_OFF, 32'h05);
        wr(`MRX_FDATA_OFF, 32'h00);
        wr(`MRX_CMD_OFF, cmd(OP_FILE_MOVE_WITH_TEST, 1'b0, 6'h05, 8'h00));
        chk("work", `MRX_WORK_OFF, 32'h0);
        chk("flags", `MRX_FLAGS_OFF, 32'h1);
        wr(`MRX_FADDR_OFF, 32'h06);
        wr(`MRX_FDATA_OFF, 32'h3c);
        wr(`MRX_CMD_OFF, cmd(OP_FILE_MOVE_WITH_TEST, 1'b1, 6'h06, 8'h00));
        chk("flags", `MRX_FLAGS_OFF, 32'h0);
        chk("file", `MRX_FDATA_OFF, 32'h3c);
        chk("work", `MRX_WORK_OFF, 32'h0);
        $display("move test done");
        wr(`MRX_FLAGS_OFF, 32'h1);
        wr(`MRX_CMD_OFF, cmd(OP_NOP, 1'b1, 6'h06, 8'h11));
        chk("pc", `MRX_PC_OFF, 32'h4);
        chk("work", `MRX_WORK_OFF, 32'h0);
        chk("flags", `MRX_FLAGS_OFF, 32'h1);
        chk("file", `MRX_FDATA_OFF, 32'h3c);
        // unused op codes behave as a no-operation
        wr(`MRX_CMD_OFF, cmd(3'h7, 1'b1, 6'h06, 8'h22));
        chk("pc", `MRX_PC_OFF, 32'h5);
        $display("nop test done");
        wr(`MRX_STACK_OFF, 32'h155);
        wr(`MRX_STACK_OFF, 32'h2aa);
        wr(`MRX_STACK_OFF, 32'h0f0);
        wr(`MRX_FLAGS_OFF, 32'h1);
        wr(`MRX_CMD_OFF, cmd(OP_RETURN_WITH_LITERAL, 1'b0, 6'h00, 8'hfe));
        chk("pc", `MRX_PC_OFF, 32'h0f0);
        chk("level", `MRX_LEVEL_OFF, 32'h2);
        chk("work", `MRX_WORK_OFF, 32'hfe);
        chk("flags", `MRX_FLAGS_OFF, 32'h3);
        wr(`MRX_FLAGS_OFF, 32'h0);
        wr(`MRX_CMD_OFF, cmd(OP_RETURN_FROM_IRQ, 1'b0, 6'h00, 8'h00));
        chk("pc", `MRX_PC_OFF, 32'h2aa);
        chk("flags", `MRX_FLAGS_OFF, 32'h2);
        chk_bit("irq enable pin", 1'b1, GLOBAL_IRQ_ENABLE);
        wr(`MRX_FLAGS_OFF, 32'h1);
        wr(`MRX_CMD_OFF, cmd(OP_SUBROUTINE_RETURN, 1'b0, 6'h00, 8'h00));
        // clock enable low freezes the return in its second cycle
        CE <= 1'b0;
        repeat (4) @(posedge CLOCK);
        chk_bit("busy frozen", 1'b1, BUSY);
        CE <= 1'b1;
        chk("pc", `MRX_PC_OFF, 32'h155);
        chk("level", `MRX_LEVEL_OFF, 32'h0);
        chk("flags", `MRX_FLAGS_OFF, 32'h1);
        chk_bit("irq enable pin", 1'b0, GLOBAL_IRQ_ENABLE);
        $display("return test done");
        // second reset in mid-run clears pc, work, level and flags left by the tests, not the file registers
        RST_B <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RST_B <= 1'b1;
        chk("pc", `MRX_PC_OFF, 32'h0);
        chk("work", `MRX_WORK_OFF, 32'h0);
        chk("level", `MRX_LEVEL_OFF, 32'h0);
        chk("flags", `MRX_FLAGS_OFF, 32'h0);
        chk_bit("irq enable pin", 1'b0, GLOBAL_IRQ_ENABLE);
        $display("reset again test done");
        summarize();
    end
endmodule
`default_nettype wire
